// *** hw/dpsb_pkg.sv ***
// Package of constants for the data prefetch stream buffer
package dpsb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ENTRIES = 8;             // Stream entries
  localparam int ENT_W = 3;
  localparam int HALVES = 16;             // Two 64-byte halves per entry
  localparam int HALF_W = 4;
  localparam int HALF_BYTES = 64;
  localparam int LINE_BYTES = 128;
  localparam int HALF_DATA_W = HALF_BYTES * 8;
  localparam int BLK_W = 26;              // Address bits above the 64-byte offset
  localparam int GEN_W = 3;               // Owner tag width per half
  localparam int ATTR_N = 16;             // Attribute regions of 16 MB each

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ATTR_PFE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_L2_DIS = 0;         // Second-level cache disabled
  localparam int CTRL_L2_ZERO = 1;        // Second-level cache sized zero
  localparam int CTRL_L2_FRZ = 2;         // Second-level cache frozen
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  // Regions 12-15 (0x0C000000-0x0FFFFFFF) prefetch enabled at reset
  localparam logic [ATTR_N-1:0] ATTR_PFE_RST = 16'hF000;

  localparam int EV_STALE = 0;            // Stale return discarded
  localparam int EV_ALLOC = 1;            // Stream allocated
  localparam int EV_LOOKBACK = 2;         // Look-back re-fetch queued
  localparam int EV_CANCEL = 3;           // Fresh return came back cancelled
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;

  localparam int STATE_PTR_LSB = 0;
  localparam int STATE_VALID_LSB = 8;

endpackage

// *** hw/dpsb_top.sv ***
// Data prefetch stream buffer with APB control and memory-controller port
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

module dpsb_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Demand accesses from first- or second-level cache
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_from_l2,
  input wire logic [31:0] req_addr,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_hit,
  output logic [dpsb_pkg::HALF_DATA_W-1:0] resp_data,
  // Prefetch requests to the shared memory controller
  output logic pf_valid,
  input wire logic pf_ready,
  output logic [31:0] pf_addr,
  output logic [dpsb_pkg::HALF_W-1:0] pf_slot,
  output logic [dpsb_pkg::GEN_W-1:0] pf_gen,
  // Prefetch returns from the shared memory controller
  input wire logic ret_valid,
  input wire logic ret_ok,
  input wire logic [dpsb_pkg::HALF_W-1:0] ret_slot,
  input wire logic [dpsb_pkg::GEN_W-1:0] ret_gen,
  input wire logic [dpsb_pkg::HALF_DATA_W-1:0] ret_data,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [dpsb_pkg::HALF_DATA_W-1:0] half_data [dpsb_pkg::HALVES];
  logic [dpsb_pkg::HALVES-1:0] half_dv;
  logic [dpsb_pkg::HALVES-1:0] half_pend;
  logic [dpsb_pkg::GEN_W-1:0] half_gen [dpsb_pkg::HALVES];
  logic [dpsb_pkg::ENTRIES-1:0] ent_valid;
  logic [dpsb_pkg::BLK_W-1:0] ent_base [dpsb_pkg::ENTRIES];
  logic [dpsb_pkg::ENT_W-1:0] alloc_ptr;
  logic cand_valid;
  logic [dpsb_pkg::BLK_W-1:0] cand_blk;

  // Queued prefetches waiting for the output stage
  logic s1_pend;
  logic s2_pend;
  logic [dpsb_pkg::ENT_W-1:0] s_ent;
  logic [dpsb_pkg::BLK_W-1:0] s_base;
  logic lb_pend;
  logic [dpsb_pkg::HALF_W-1:0] lb_half;
  logic [dpsb_pkg::BLK_W-1:0] lb_blk;

  // Registers
  logic [dpsb_pkg::CTRL_W-1:0] ctrl;
  logic [dpsb_pkg::ATTR_N-1:0] attr_pfe;
  logic [dpsb_pkg::EV_W-1:0] ev_status;
  logic [dpsb_pkg::EV_W-1:0] ev_mask;

  // ----------------------------------------------------------------
  // Demand decode
  // ----------------------------------------------------------------
  logic [dpsb_pkg::BLK_W-1:0] blk;
  logic match_hit;
  logic [dpsb_pkg::ENT_W-1:0] match_ent;
  logic match_half;

  assign blk = req_addr[31:6];

  // Stream match: entry covers base block and the block above it
  always_comb begin
    match_hit = 1'b0;
    match_ent = '0;
    match_half = 1'b0;
    for (int i = 0; i < dpsb_pkg::ENTRIES; i++) begin
      if (ent_valid[i] && (blk == ent_base[i] || blk == ent_base[i] + 26'h1)) begin
        match_hit = 1'b1;
        match_ent = 3'(i);
        match_half = (blk != ent_base[i]);
      end
    end
  end

  wire [dpsb_pkg::HALF_W-1:0] hidx = {match_ent, match_half};
  wire [dpsb_pkg::HALF_W-1:0] oidx = {match_ent, ~match_half};
  wire [dpsb_pkg::BLK_W-1:0] blk_next = blk + 26'h1;
  // Second-level cache unusable falls back to first-level handling
  wire l2_off = ctrl[dpsb_pkg::CTRL_L2_DIS] | ctrl[dpsb_pkg::CTRL_L2_ZERO] |
                ctrl[dpsb_pkg::CTRL_L2_FRZ];
  wire l1_mode = ~req_from_l2 | l2_off;
  // Only the low 256 MB has attribute bits here; other space never prefetches
  wire pf_ok = (req_addr[31:28] == 4'h0) & attr_pfe[req_addr[27:24]];
  wire half_wait = match_hit & half_pend[hidx] & ~half_dv[hidx];
  wire data_hit = match_hit & half_dv[hidx];
  wire cand_hit = cand_valid & (blk == cand_blk + 26'h1);

  // Reads to a half with a fetch in flight stall until it returns
  assign req_ready = ~(req_valid & ~req_write & half_wait);
  wire rd_take = req_valid & ~req_write & req_ready;
  wire wr_inval = req_valid & req_write & match_hit;
  wire alloc_now = rd_take & pf_ok & (cand_hit | match_hit);
  // Look-back only while the other half is empty and idle
  wire lb_now = rd_take & pf_ok & l1_mode & match_hit & ~lb_pend &
                ~half_dv[oidx] & ~half_pend[oidx] &
                ~(alloc_now & (match_ent == alloc_ptr));

  // ----------------------------------------------------------------
  // Prefetch output stage select
  // ----------------------------------------------------------------
  // Loading is held off in an allocation cycle so one half never sees
  // two tag bumps on one edge; costs one cycle of issue bandwidth.
  wire load_ok = ~alloc_now & (~pf_valid | pf_ready);
  wire load_s1 = load_ok & s1_pend;
  wire load_s2 = load_ok & ~s1_pend & s2_pend;
  wire load_lb = load_ok & ~s1_pend & ~s2_pend & lb_pend;
  wire load_go = load_s1 | load_s2 | load_lb;
  wire [dpsb_pkg::HALF_W-1:0] load_half = load_s1 ? {s_ent, 1'b0} :
                                          load_s2 ? {s_ent, 1'b1} : lb_half;
  wire [dpsb_pkg::BLK_W-1:0] load_blk = load_s1 ? s_base :
                                        load_s2 ? s_base + 26'h1 : lb_blk;
  wire [dpsb_pkg::GEN_W-1:0] load_gen = half_gen[load_half] + 3'h1;

  // Return is accepted for the slot only if it carries the owner tag
  wire ret_fresh = ret_valid & half_pend[ret_slot] &
                   (ret_gen == half_gen[ret_slot]);
  wire ret_stale = ret_valid & ~ret_fresh;

  // ----------------------------------------------------------------
  // Half slot state
  // ----------------------------------------------------------------
  // Later statements win: return, write invalidate, load, reallocation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_dv <= '0;
      half_pend <= '0;
      for (int i = 0; i < dpsb_pkg::HALVES; i++) begin
        half_gen[i] <= '0;
      end
    end else begin
      if (ret_fresh) begin
        half_pend[ret_slot] <= 1'b0;
        half_dv[ret_slot] <= ret_ok;
      end
      if (wr_inval) begin
        half_dv[hidx] <= 1'b0;
      end
      if (load_go) begin
        half_gen[load_half] <= load_gen;
        half_pend[load_half] <= 1'b1;
        half_dv[load_half] <= 1'b0;
      end
      if (alloc_now) begin
        // Tag bump orphans anything in flight, including a request
        // leaving the output stage on this very edge
        half_gen[{alloc_ptr, 1'b0}] <= half_gen[{alloc_ptr, 1'b0}] + 3'h1;
        half_gen[{alloc_ptr, 1'b1}] <= half_gen[{alloc_ptr, 1'b1}] + 3'h1;
        half_pend[{alloc_ptr, 1'b0}] <= 1'b0;
        half_pend[{alloc_ptr, 1'b1}] <= 1'b0;
        half_dv[{alloc_ptr, 1'b0}] <= 1'b0;
        half_dv[{alloc_ptr, 1'b1}] <= 1'b0;
      end
    end
  end

  // Half data written only by fresh successful returns
  always_ff @(posedge pclk) begin
    if (ret_fresh && ret_ok) begin
      half_data[ret_slot] <= ret_data;
    end
  end

  // ----------------------------------------------------------------
  // Stream entries, candidate and allocation pointer
  // ----------------------------------------------------------------
  // Round-robin pointer names the next entry to fill, which is the oldest allocation once all eight entries have been used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_valid <= '0;
      alloc_ptr <= '0;
      cand_valid <= 1'b0;
      cand_blk <= '0;
      for (int i = 0; i < dpsb_pkg::ENTRIES; i++) begin
        ent_base[i] <= '0;
      end
    end else begin
      if (alloc_now) begin
        ent_valid[alloc_ptr] <= 1'b1;
        ent_base[alloc_ptr] <= blk_next;
        alloc_ptr <= alloc_ptr + 3'h1;
      end
      if (rd_take && pf_ok && !match_hit) begin
        cand_valid <= 1'b1;
        cand_blk <= blk;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prefetch queue and output stage
  // ----------------------------------------------------------------
  // Allocation overrides any unissued pair from an older stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_pend <= 1'b0;
      s2_pend <= 1'b0;
      s_ent <= '0;
      s_base <= '0;
      lb_pend <= 1'b0;
      lb_half <= '0;
      lb_blk <= '0;
    end else begin
      if (load_s1) begin
        s1_pend <= 1'b0;
      end
      if (load_s2) begin
        s2_pend <= 1'b0;
      end
      if (load_lb) begin
        lb_pend <= 1'b0;
      end
      if (alloc_now) begin
        s1_pend <= 1'b1;
        s2_pend <= 1'b1;
        s_ent <= alloc_ptr;
        s_base <= blk_next;
        if (lb_pend && lb_half[3:1] == alloc_ptr) begin
          lb_pend <= 1'b0;
        end
      end
      if (lb_now) begin
        lb_pend <= 1'b1;
        lb_half <= oidx;
        lb_blk <= match_half ? blk - 26'h1 : blk_next;
      end
    end
  end

  // Output stage holds its request while the controller stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_valid <= 1'b0;
      pf_addr <= '0;
      pf_slot <= '0;
      pf_gen <= '0;
    end else if (load_go) begin
      pf_valid <= 1'b1;
      pf_addr <= {load_blk, 6'h00};
      pf_slot <= load_half;
      pf_gen <= load_gen;
    end else if (pf_ready) begin
      pf_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Demand response
  // ----------------------------------------------------------------
  // Miss or address hit answers with resp_hit low: forward to controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_hit <= 1'b0;
      resp_data <= '0;
    end else begin
      resp_valid <= rd_take;
      resp_hit <= rd_take & data_hit;
      if (rd_take && data_hit) begin
        resp_data <= half_data[hidx];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire sel_ctrl = (paddr == dpsb_pkg::OFF_CTRL);
  wire sel_attr = (paddr == dpsb_pkg::OFF_ATTR_PFE);
  wire sel_stat = (paddr == dpsb_pkg::OFF_STATUS);
  wire sel_mask = (paddr == dpsb_pkg::OFF_MASK);
  wire sel_state = (paddr == dpsb_pkg::OFF_STATE);
  wire mapped = sel_ctrl | sel_attr | sel_stat | sel_mask | sel_state;
  wire acc = psel & penable;
  // User-mode writes to attribute bits are refused with an error
  wire attr_deny = pwrite & sel_attr & ~pprot[0];
  wire wr_ok = acc & pwrite & mapped & ~attr_deny;
  wire stat_rd = acc & ~pwrite & sel_stat;
  wire [dpsb_pkg::EV_W-1:0] ev_set;

  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | attr_deny);
  assign ev_set[dpsb_pkg::EV_STALE] = ret_stale;
  assign ev_set[dpsb_pkg::EV_ALLOC] = alloc_now;
  assign ev_set[dpsb_pkg::EV_LOOKBACK] = lb_now;
  assign ev_set[dpsb_pkg::EV_CANCEL] = ret_fresh & ~ret_ok;
  assign irq = |(ev_status & ev_mask);

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    sel_ctrl ? {29'h0, ctrl} :
    sel_attr ? {16'h0, attr_pfe} :
    sel_stat ? {28'h0, ev_status} :
    sel_mask ? {28'h0, ev_mask} :
    sel_state ? {16'h0, ent_valid, 5'h00, alloc_ptr} : 32'h0000_0000;

  // Control registers written in the access phase; read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dpsb_pkg::CTRL_RST;
      attr_pfe <= dpsb_pkg::ATTR_PFE_RST;
      ev_mask <= dpsb_pkg::EV_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_ok && sel_ctrl) begin
        ctrl <= pwdata[dpsb_pkg::CTRL_W-1:0];
      end
      if (wr_ok && sel_attr) begin
        attr_pfe <= pwdata[dpsb_pkg::ATTR_N-1:0];
      end
      if (wr_ok && sel_mask) begin
        ev_mask <= pwdata[dpsb_pkg::EV_W-1:0];
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Sticky events: a read clears only the bits it reported; sets win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status <= dpsb_pkg::EV_RST;
    end else begin
      ev_status <= (ev_status & ~(stat_rd ? prdata[dpsb_pkg::EV_W-1:0] : '0)) | ev_set;
    end
  end

endmodule

// *** sim/dpsb_mem_model.sv ***
// Shared memory controller model answering prefetch reads
`timescale 1ns/10ps
module dpsb_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control: hold back returns, cancel returns
  input wire logic hold,
  input wire logic cancel,
  // Requests
  input wire logic pf_valid,
  output logic pf_ready,
  input wire logic [31:0] pf_addr,
  input wire logic [3:0] pf_slot,
  input wire logic [2:0] pf_gen,
  // Returns
  output logic ret_valid,
  output logic ret_ok,
  output logic [3:0] ret_slot,
  output logic [2:0] ret_gen,
  output logic [511:0] ret_data
);
  logic [38:0] q [$];
  logic [38:0] e;
  // Accept every other cycle; return in order, one per cycle
  // Idle return lines toggle so stale values never look valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      pf_ready <= 1'h0;
      ret_valid <= 1'h0;
      ret_ok <= 1'h0;
      ret_slot <= 4'h0;
      ret_gen <= 3'h0;
      ret_data <= '0;
    end else begin
      pf_ready <= ~pf_ready;
      if (pf_valid && pf_ready) begin
        q.push_back({pf_addr, pf_slot, pf_gen});
      end
      if (!hold && q.size() > 0) begin
        e = q.pop_front();
        ret_valid <= 1'h1;
        ret_ok <= !cancel;
        ret_slot <= e[6:3];
        ret_gen <= e[2:0];
        ret_data <= {16{e[38:7]}};
      end else begin
        ret_valid <= 1'h0;
        ret_slot <= ~ret_slot;
        ret_gen <= ~ret_gen;
        ret_data <= ~ret_data;
      end
    end
  end
endmodule

// *** sim/dpsb_top_asserts.sv ***
// Port checker for the prefetch stream buffer
`timescale 1ns/10ps
module dpsb_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [2:0] pprot,
  input wire logic pslverr,
  // Demand side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_hit,
  // Prefetch side
  input wire logic pf_valid,
  input wire logic pf_ready,
  input wire logic [31:0] pf_addr,
  input wire logic [3:0] pf_slot,
  input wire logic [2:0] pf_gen,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------
  // Owner tag last issued per half
  // ----------
  logic [2:0] last_gen [16];
  logic [15:0] seen;
  // Only halves issued since reset are compared, so a second reset starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= '0;
    end else if (pf_valid && pf_ready) begin
      seen[pf_slot] <= 1'h1;
      last_gen[pf_slot] <= pf_gen;
    end
  end
  // ----------
  // Assertions
  // ----------
  a_read_answer: assert property (
    resp_valid == $past(req_valid && req_ready && !req_write))
    else $error("read answer not one cycle after take");
  a_hit_in_answer: assert property (resp_hit |-> resp_valid)
    else $error("hit flag outside an answer");
  a_pf_holds: assert property (
    pf_valid && !pf_ready |=> pf_valid && $stable({pf_addr, pf_slot, pf_gen}))
    else $error("prefetch request changed while stalled");
  a_pf_aligned: assert property (pf_valid |-> pf_addr[5:0] == 6'h00)
    else $error("prefetch not on a 64-byte half");
  a_pf_region: assert property (pf_valid |-> pf_addr[31:28] == 4'h0)
    else $error("prefetch outside attribute regions");
  a_gen_renewed: assert property (
    pf_valid && pf_ready && seen[pf_slot] |-> pf_gen != last_gen[pf_slot])
    else $error("half reissued with same owner tag");
  a_write_taken: assert property (req_valid && req_write |-> req_ready)
    else $error("write was held off");
  a_user_refused: assert property (
    psel && penable && pwrite && paddr == dpsb_pkg::OFF_ATTR_PFE && !pprot[0] |-> pslverr)
    else $error("user write to attributes not refused");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  // Main scenarios reached
  c_pf_stall: cover property (pf_valid && !pf_ready);
  c_req_wait: cover property (req_valid && !req_ready);
  c_irq: cover property (irq);
endmodule

bind dpsb_top dpsb_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pprot, .pslverr,
  .req_valid, .req_write, .req_ready, .resp_valid, .resp_hit, .pf_valid, .pf_ready, .pf_addr,
  .pf_slot, .pf_gen, .irq);

// *** sim/tb_top.sv ***
// Self-checking bench for the prefetch stream buffer
`timescale 1ns/10ps
module tb_top;
  // ----------
  // Signals
  // ----------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = '0, prdata, r, pf_addr;
  logic [31:0] req_addr = '0;
  logic [2:0] pprot = 3'h1;
  logic req_valid = 1'h0, req_write = 1'h0, req_from_l2 = 1'h0;
  logic hold = 1'h0, cancel = 1'h0;
  logic pready, pslverr, req_ready, resp_valid, resp_hit, pf_valid, pf_ready;
  logic ret_valid, ret_ok, irq, err, hit, stalled;
  logic [dpsb_pkg::HALF_DATA_W-1:0] resp_data, ret_data, rdat;
  logic [3:0] pf_slot, ret_slot;
  logic [2:0] pf_gen, ret_gen;
  logic [2:0] lb_ctrl [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
  logic [31:0] pf_log [$];
  int mismatches = 0, check_count = 0, n0;

  dpsb_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
    .pready, .pslverr, .req_valid, .req_write, .req_from_l2, .req_addr, .req_ready, .resp_valid,
    .resp_hit, .resp_data, .pf_valid, .pf_ready, .pf_addr, .pf_slot, .pf_gen, .ret_valid,
    .ret_ok, .ret_slot, .ret_gen, .ret_data, .irq);
  dpsb_mem_model i_mem (.pclk, .presetn, .hold, .cancel, .pf_valid, .pf_ready, .pf_addr,
    .pf_slot, .pf_gen, .ret_valid, .ret_ok, .ret_slot, .ret_gen, .ret_data);

  // Clock and a log of accepted prefetch addresses
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (pf_valid && pf_ready) begin
      pf_log.push_back(pf_addr);
    end
  end
  // ----------
  // Tasks
  // ----------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Waits are bounded; running out counts as a mismatch
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      conclude();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic dem(input logic w, input logic l2, input logic [31:0] a);
    int n;
    n = 0;
    req_valid <= 1'h1;
    req_write <= w;
    req_from_l2 <= l2;
    req_addr <= a;
    do begin
      @(posedge pclk);
      n++;
    end while (req_ready !== 1'h1 && n < 100);
    if (req_ready !== 1'h1) begin
      mismatches++;
      conclude();
    end
    stalled = n > 1;
    req_valid <= 1'h0;
    @(posedge pclk);
    hit = resp_hit;
    rdat = resp_data;
    if (!w) begin
      chk(resp_valid, 1'h1);
    end
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(0, dpsb_pkg::OFF_ATTR_PFE, 0);
    chk(r, 32'h0000_F000);
    apb(0, 8'h14, 0);
    chk(err, 1'h1);
    apb(1, dpsb_pkg::OFF_MASK, 32'h0000_000F);
    $display("test reset done");
    // Miss then its neighbour starts a stream one block ahead
    hold <= 1'h1;
    dem(0, 0, 32'h0C00_0000);
    dem(0, 0, 32'h0C00_0040);
    repeat (8) @(posedge pclk);
    chk({pf_log[0], pf_log[1]}, {32'h0C00_0080, 32'h0C00_00C0});
    apb(0, dpsb_pkg::OFF_STATE, 0);
    chk(r, 32'h0000_0101);
    chk(irq, 1'h1);
    apb(0, dpsb_pkg::OFF_STATUS, 0);
    chk(r, 32'h0000_0002);
    chk(irq, 1'h0);
    // Read of an in-flight half waits for the return
    fork
      dem(0, 0, 32'h0C00_0080);
      begin
        repeat (10) @(posedge pclk);
        hold <= 1'h0;
      end
    join
    chk({stalled, hit}, 2'h3);
    chk(rdat, {16{32'h0C00_0080}});
    repeat (10) @(posedge pclk);
    dem(1, 0, 32'h0C00_0080);
    dem(0, 0, 32'h0C00_0080);
    chk(hit, 1'h0);
    $display("test stream done");
    // Look-back per requester and second-level state
    // Each pass builds a fresh stream, empties its upper half, then reads the lower
    for (int k = 0; k < 5; k++) begin
      apb(1, dpsb_pkg::OFF_CTRL, lb_ctrl[k]);
      dem(0, 0, 32'h0C20_0000 + (k << 16));
      dem(0, 0, 32'h0C20_0040 + (k << 16));
      repeat (8) @(posedge pclk);
      dem(1, 0, 32'h0C20_00C0 + (k << 16));
      apb(0, dpsb_pkg::OFF_STATUS, 0);
      dem(0, k < 4, 32'h0C20_0080 + (k << 16));
      chk(hit, 1'h1);
      repeat (4) @(posedge pclk);
      apb(0, dpsb_pkg::OFF_STATUS, 0);
      chk(r[2], k > 0);
    end
    $display("test look-back done");
    // Disabled region starts nothing; user writes refused
    apb(1, dpsb_pkg::OFF_ATTR_PFE, 32'h0000_E000);
    repeat (8) @(posedge pclk);
    apb(0, dpsb_pkg::OFF_STATUS, 0);
    n0 = pf_log.size();
    dem(0, 0, 32'h0C10_0000);
    dem(0, 0, 32'h0C10_0040);
    repeat (6) @(posedge pclk);
    apb(0, dpsb_pkg::OFF_STATUS, 0);
    chk({r[1], pf_log.size() - n0}, 0);
    pprot <= 3'h0;
    apb(1, dpsb_pkg::OFF_ATTR_PFE, 32'h0000_FFFF);
    chk(err, 1'h1);
    pprot <= 3'h1;
    apb(0, dpsb_pkg::OFF_ATTR_PFE, 0);
    chk(r, 32'h0000_E000);
    apb(1, dpsb_pkg::OFF_ATTR_PFE, 32'h0000_F000);
    $display("test attributes done");
    // Ninth stream reuses entry with held fetches; first stale one cancelled
    hold <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      dem(0, 0, 32'h0D00_0000 + (i << 16));
      dem(0, 0, 32'h0D00_0040 + (i << 16));
      repeat (6) @(posedge pclk);
    end
    apb(1, dpsb_pkg::OFF_MASK, 0);
    apb(0, dpsb_pkg::OFF_STATUS, 0);
    hold <= 1'h0;
    cancel <= 1'h1;
    @(posedge pclk);
    cancel <= 1'h0;
    repeat (40) @(posedge pclk);
    chk(irq, 1'h0);
    apb(1, dpsb_pkg::OFF_MASK, 32'h0000_0001);
    chk(irq, 1'h1);
    apb(0, dpsb_pkg::OFF_STATUS, 0);
    chk(r[0], 1'h1);
    dem(0, 0, 32'h0D08_0080);
    chk(hit, 1'h1);
    chk(rdat, {16{32'h0D08_0080}});
    dem(0, 0, 32'h0D08_00C0);
    chk(rdat, {16{32'h0D08_00C0}});
    $display("test stale done");
    conclude();
  end
endmodule
